// ===== mrz_device.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module mrz_device (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	mrz_cmd_if.dev LINK,
	input wire logic [4:0] ADDITIVE_LAT_I,
	input wire logic TERM_ENABLED_I,
	output logic [4:0] WR_CYCLES_O,
	output logic [3:0] RTP_CYCLES_O,
	output logic [5:0] CAS_LAT_O,
	output logic [6:0] READ_LAT_O,
	output logic BURST_ORDER_O,
	output logic [1:0] BURST_SIZE_O,
	output logic DLL_RESET_O,
	output logic TEST_MODE_O,
	output logic MODE_BUSY_O,
	output logic [mrz_pkg::VIO_W-1:0] VIOLATION_O
);

	// ****************************************
	// Command decode
	// ****************************************
	wire cmd_sel = LINK.cke & ~LINK.cs_n;
	wire mrs_cmd = cmd_sel & ~LINK.ras_n & ~LINK.cas_n & ~LINK.we_n;
	wire other_cmd = cmd_sel & ~mrs_cmd;

	// Pin to bit mapping of the incoming image
	wire [mrz_pkg::MR_W-1:0] pin_img = {LINK.group_select_pins, LINK.bank, LINK.addr17,
		3'h0, LINK.addr};
	wire [2:0] pin_sel = pin_img[mrz_pkg::SEL_LSB +: mrz_pkg::SEL_W];
	wire mr0_write = mrs_cmd & (pin_sel == mrz_pkg::SEL_MR0);
	wire sel_bad = mrs_cmd & (pin_sel == mrz_pkg::SEL_FORBIDDEN);
	wire rsvd_bad = mrs_cmd & (pin_img[mrz_pkg::RFU_HI_BIT] | pin_img[mrz_pkg::RFU_LO_BIT]);
	wire dll_start = mr0_write & pin_img[mrz_pkg::DLL_BIT];

	// ****************************************
	// Register zero and field decode
	// ****************************************
	logic [mrz_pkg::MR_W-1:0] mr0_q;
	logic dll_reset_q;
	logic [7:0] dll_cnt_q;
	logic [7:0] mod_cnt_q;
	logic [mrz_pkg::VIO_W-1:0] vio_q;

	wire [3:0] wr_code = {mr0_q[mrz_pkg::WR_HI_BIT], mr0_q[mrz_pkg::WR_LO_LSB +: 3]};
	wire [4:0] cl_code = {mr0_q[mrz_pkg::CL_HI_BIT], mr0_q[mrz_pkg::CL_MID_LSB +: 3],
		mr0_q[mrz_pkg::CL_LO_BIT]};
	wire [1:0] bsize = mr0_q[mrz_pkg::BSIZE_LSB +: 2];
	wire [4:0] wr_cyc;
	wire [3:0] rtp_cyc;
	wire [5:0] cl_cyc;
	wire wr_rsvd;
	wire cl_rsvd;

	mrz_lat_decode u_decode (
		.wr_code_i(wr_code),
		.cl_code_i(cl_code),
		.wr_cyc_o(wr_cyc),
		.rtp_cyc_o(rtp_cyc),
		.cl_cyc_o(cl_cyc),
		.wr_rsvd_o(wr_rsvd),
		.cl_rsvd_o(cl_rsvd)
	);

	wire [6:0] read_lat = {2'h0, ADDITIVE_LAT_I} + {1'b0, cl_cyc};
	wire bsize_rsvd = (bsize == mrz_pkg::BSIZE_RSVD);
	wire code_bad = wr_rsvd | cl_rsvd | bsize_rsvd;
	wire order_bit = mr0_q[mrz_pkg::ORDER_BIT];
	wire test_bit = mr0_q[mrz_pkg::TEST_BIT];

	// Any mode write restarts the update window; slow settings are not tracked here
	wire mod_busy = (mod_cnt_q != 8'h00);
	wire early_bad = other_cmd & mod_busy;
	wire term_bad = TERM_ENABLED_I & LINK.termination_enable_pin & (mrs_cmd | mod_busy);
	wire dll_done = dll_reset_q & (dll_cnt_q == 8'h01);

	// Whole image loads at once; only the DLL bit is cleared alone, when the DLL reset ends
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mr0_q <= '0;
		end else if (mr0_write) begin
			mr0_q <= pin_img;
		end else if (dll_done) begin
			mr0_q[mrz_pkg::DLL_BIT] <= 1'b0;
		end
	end

	// ****************************************
	// DLL reset sequencing
	// ****************************************
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			dll_reset_q <= 1'b0;
			dll_cnt_q <= 8'h00;
		end else if (dll_start) begin
			dll_reset_q <= 1'b1;
			dll_cnt_q <= mrz_pkg::DLL_RESET_CK;
		end else if (dll_done) begin
			dll_reset_q <= 1'b0;
			dll_cnt_q <= 8'h00;
		end else if (dll_reset_q) begin
			dll_cnt_q <= dll_cnt_q - 8'h01;
		end
	end

	// ****************************************
	// Update window after a mode write
	// ****************************************
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mod_cnt_q <= 8'h00;
		end else if (mrs_cmd) begin
			mod_cnt_q <= mrz_pkg::MOD_DELAY_CK;
		end else if (mod_busy) begin
			mod_cnt_q <= mod_cnt_q - 8'h01;
		end
	end

	// Sticky until reset, so a single bad command is never missed
	wire [mrz_pkg::VIO_W-1:0] vio_set;
	assign vio_set[mrz_pkg::VIO_RSVD_BIT] = rsvd_bad;
	assign vio_set[mrz_pkg::VIO_SEL_BIT] = sel_bad;
	assign vio_set[mrz_pkg::VIO_CODE_BIT] = code_bad;
	assign vio_set[mrz_pkg::VIO_EARLY_BIT] = early_bad;
	assign vio_set[mrz_pkg::VIO_TERM_BIT] = term_bad;

	generate
		for (genvar gi = 0; gi < mrz_pkg::VIO_W; gi++) begin : g_vio
			always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					vio_q[gi] <= 1'b0;
				end else if (vio_set[gi]) begin
					vio_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// ****************************************
	// Registered timing outputs
	// ****************************************
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			WR_CYCLES_O <= '0;
			RTP_CYCLES_O <= '0;
			CAS_LAT_O <= '0;
			READ_LAT_O <= '0;
		end else begin
			WR_CYCLES_O <= wr_cyc;
			RTP_CYCLES_O <= rtp_cyc;
			CAS_LAT_O <= cl_cyc;
			READ_LAT_O <= read_lat;
		end
	end

	// ****************************************
	// Registered burst outputs
	// ****************************************
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			BURST_ORDER_O <= 1'b0;
			BURST_SIZE_O <= 2'h0;
		end else begin
			BURST_ORDER_O <= order_bit;
			BURST_SIZE_O <= bsize;
		end
	end

	// ****************************************
	// Registered status outputs
	// ****************************************
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			DLL_RESET_O <= 1'b0;
			TEST_MODE_O <= 1'b0;
			MODE_BUSY_O <= 1'b0;
			VIOLATION_O <= '0;
		end else begin
			DLL_RESET_O <= dll_reset_q;
			TEST_MODE_O <= test_bit;
			MODE_BUSY_O <= mod_busy;
			VIOLATION_O <= vio_q;
		end
	end

endmodule : mrz_device

// ===== mrz_pkg.sv
package mrz_pkg;

	// ****************************************
	// Mode register image layout
	// ****************************************
	localparam int MR_W = 22;
	localparam int RFU_HI_BIT = 21;
	localparam int SEL_LSB = 18;
	localparam int SEL_W = 3;
	localparam int RFU_LO_BIT = 17;
	localparam int WR_HI_BIT = 13;
	localparam int CL_HI_BIT = 12;
	localparam int WR_LO_LSB = 9;
	localparam int DLL_BIT = 8;
	localparam int TEST_BIT = 7;
	localparam int CL_MID_LSB = 4;
	localparam int ORDER_BIT = 3;
	localparam int CL_LO_BIT = 2;
	localparam int BSIZE_LSB = 0;

	localparam logic [2:0] SEL_MR0 = 3'h0;
	localparam logic [2:0] SEL_FORBIDDEN = 3'h7;
	localparam logic [3:0] WR_CODE_MAX = 4'h9;
	localparam logic [1:0] BSIZE_RSVD = 2'h3;
	localparam logic [5:0] CL_STACK_A = 6'h19;
	localparam logic [5:0] CL_STACK_B = 6'h1B;

	// ****************************************
	// Timing counts, in command clocks
	// ****************************************
	localparam logic [7:0] MOD_DELAY_CK = 8'h18;
	localparam logic [7:0] DLL_RESET_CK = 8'h10;

	// ****************************************
	// Device violation flags
	// ****************************************
	localparam int VIO_W = 5;
	localparam int VIO_RSVD_BIT = 0;
	localparam int VIO_SEL_BIT = 1;
	localparam int VIO_CODE_BIT = 2;
	localparam int VIO_EARLY_BIT = 3;
	localparam int VIO_TERM_BIT = 4;

	// ****************************************
	// Controller registers on APB
	// ****************************************
	localparam logic [7:0] OFS_IMAGE = 8'h00;
	localparam logic [7:0] OFS_COMMAND = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [21:0] IMAGE_RST = 22'h000000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HOLD,
		ST_ISSUE,
		ST_WAIT
	} mrz_ctrl_e;

endpackage : mrz_pkg

// ===== mrz_cmd_if.sv
`timescale 1ns/1ns
interface mrz_cmd_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] group_select_pins;
	logic [1:0] bank;
	logic addr17;
	logic [13:0] addr;
	logic termination_enable_pin;

	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, group_select_pins, bank, addr17, addr,
		termination_enable_pin);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, group_select_pins, bank, addr17, addr,
		termination_enable_pin);
endinterface : mrz_cmd_if

// ===== mrz_lat_decode.sv
`timescale 1ns/1ns
module mrz_lat_decode (
	input wire logic [3:0] wr_code_i,
	input wire logic [4:0] cl_code_i,
	output logic [4:0] wr_cyc_o,
	output logic [3:0] rtp_cyc_o,
	output logic [5:0] cl_cyc_o,
	output logic wr_rsvd_o,
	output logic cl_rsvd_o
);
	// Write recovery table; read-to-precharge is always half of it
	always_comb begin
		wr_rsvd_o = 1'b0;
		unique case (wr_code_i)
			4'h0: wr_cyc_o = 5'h0A;
			4'h1: wr_cyc_o = 5'h0C;
			4'h2: wr_cyc_o = 5'h0E;
			4'h3: wr_cyc_o = 5'h10;
			4'h4: wr_cyc_o = 5'h12;
			4'h5: wr_cyc_o = 5'h14;
			4'h6: wr_cyc_o = 5'h18;
			4'h7: wr_cyc_o = 5'h16;
			4'h8: wr_cyc_o = 5'h1A;
			4'h9: wr_cyc_o = 5'h1C;
			default: begin
				wr_cyc_o = 5'h1C;
				wr_rsvd_o = 1'b1;
			end
		endcase
	end

	assign rtp_cyc_o = wr_cyc_o[4:1];

	// Latency codes 8 to 15 are not monotonic
	always_comb begin
		cl_rsvd_o = 1'b0;
		unique case (cl_code_i)
			5'h00: cl_cyc_o = 6'h09;
			5'h01: cl_cyc_o = 6'h0A;
			5'h02: cl_cyc_o = 6'h0B;
			5'h03: cl_cyc_o = 6'h0C;
			5'h04: cl_cyc_o = 6'h0D;
			5'h05: cl_cyc_o = 6'h0E;
			5'h06: cl_cyc_o = 6'h0F;
			5'h07: cl_cyc_o = 6'h10;
			5'h08: cl_cyc_o = 6'h12;
			5'h09: cl_cyc_o = 6'h14;
			5'h0A: cl_cyc_o = 6'h16;
			5'h0B: cl_cyc_o = 6'h18;
			5'h0C: cl_cyc_o = 6'h17;
			5'h0D: cl_cyc_o = 6'h11;
			5'h0E: cl_cyc_o = 6'h13;
			5'h0F: cl_cyc_o = 6'h15;
			5'h10: cl_cyc_o = 6'h19;
			5'h11: cl_cyc_o = 6'h1A;
			5'h12: cl_cyc_o = 6'h1B;
			5'h13: cl_cyc_o = 6'h1C;
			5'h14: cl_cyc_o = 6'h1D;
			5'h15: cl_cyc_o = 6'h1E;
			5'h16: cl_cyc_o = 6'h1F;
			5'h17: cl_cyc_o = 6'h20;
			default: begin
				cl_cyc_o = 6'h20;
				cl_rsvd_o = 1'b1;
			end
		endcase
	end
endmodule : mrz_lat_decode

// ===== mrz_controller.sv
`timescale 1ns/1ns
module mrz_controller #(
	parameter bit STACKED_DIE = 1'b0
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic BANKS_IDLE_I,
	input wire logic TERM_ENABLED_I,
	input wire logic GEAR_DOWN_I,
	input wire logic ODT_REQ_I,
	mrz_cmd_if.ctrl LINK
);

	// ****************************************
	// APB slave, one wait state per access
	// ****************************************
	logic [mrz_pkg::MR_W-1:0] image_q;
	logic refused_q;
	logic [7:0] wait_cnt_q;
	mrz_pkg::mrz_ctrl_e state_q;

	wire access = PSEL_I & PENABLE_I & ~PREADY_O;
	wire hit_image = (PADDR_I == mrz_pkg::OFS_IMAGE);
	wire hit_cmd = (PADDR_I == mrz_pkg::OFS_COMMAND);
	wire hit_status = (PADDR_I == mrz_pkg::OFS_STATUS);
	wire unmapped = ~(hit_image | hit_cmd | hit_status);
	wire busy = (state_q != mrz_pkg::ST_IDLE);
	wire wr_image = access & PWRITE_I & hit_image & ~busy;
	wire start = access & PWRITE_I & hit_cmd & PWDATA_I[0] & ~busy;
	wire clr_refused = access & PWRITE_I & hit_cmd;
	wire [31:0] rd_data = hit_image ? {10'h000, image_q} :
		hit_status ? {30'h0, refused_q, busy} : 32'h0;

	// ****************************************
	// Image clean-up and refusal checks
	// ****************************************
	wire [3:0] raw_wr = {image_q[mrz_pkg::WR_HI_BIT], image_q[mrz_pkg::WR_LO_LSB +: 3]};
	wire [3:0] safe_wr = (raw_wr > mrz_pkg::WR_CODE_MAX) ? mrz_pkg::WR_CODE_MAX : raw_wr;
	wire [4:0] cl_code = {image_q[mrz_pkg::CL_HI_BIT], image_q[mrz_pkg::CL_MID_LSB +: 3],
		image_q[mrz_pkg::CL_LO_BIT]};
	wire [mrz_pkg::MR_W-1:0] send_img = {1'b0, image_q[20:18], 1'b0, 3'h0, safe_wr[3],
		image_q[12], safe_wr[2:0], image_q[8], 1'b0, image_q[6:0]};
	wire [4:0] wr_cyc;
	wire [3:0] rtp_cyc;
	wire [5:0] cl_cyc;
	wire cl_rsvd;

	mrz_lat_decode u_decode (
		.wr_code_i(safe_wr),
		.cl_code_i(cl_code),
		.wr_cyc_o(wr_cyc),
		.rtp_cyc_o(rtp_cyc),
		.cl_cyc_o(cl_cyc),
		.wr_rsvd_o(),
		.cl_rsvd_o(cl_rsvd)
	);

	// Odd latency and odd read-to-precharge are the gear-down exclusions
	wire gear_bad = GEAR_DOWN_I & (cl_cyc[0] | rtp_cyc[0]);
	wire stack_bad = ~STACKED_DIE & ((cl_cyc == mrz_pkg::CL_STACK_A) |
		(cl_cyc == mrz_pkg::CL_STACK_B));
	wire sel_bad = (image_q[mrz_pkg::SEL_LSB +: mrz_pkg::SEL_W] == mrz_pkg::SEL_FORBIDDEN);
	wire refuse = gear_bad | stack_bad | sel_bad | cl_rsvd | (wr_cyc == 5'h00);

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= '0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= access;
			PRDATA_O <= (access & ~PWRITE_I) ? rd_data : 32'h0;
			PSLVERR_O <= access & unmapped;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			image_q <= mrz_pkg::IMAGE_RST;
			refused_q <= 1'b0;
		end else begin
			if (wr_image) begin
				image_q <= PWDATA_I[mrz_pkg::MR_W-1:0];
			end
			if (start && refuse) begin
				refused_q <= 1'b1;
			end else if (clr_refused) begin
				refused_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	wire ready_to_issue = BANKS_IDLE_I & LINK.cke;
	// Drop the pin from the accepting edge so it is already low before the command
	wire hold_term_low = TERM_ENABLED_I & (busy | start);

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_q <= mrz_pkg::ST_IDLE;
			wait_cnt_q <= 8'h00;
		end else begin
			unique case (state_q)
				mrz_pkg::ST_IDLE: begin
					if (start && !refuse) begin
						state_q <= mrz_pkg::ST_HOLD;
					end
				end
				mrz_pkg::ST_HOLD: begin
					if (ready_to_issue) begin
						state_q <= mrz_pkg::ST_ISSUE;
					end
				end
				mrz_pkg::ST_ISSUE: begin
					state_q <= mrz_pkg::ST_WAIT;
					wait_cnt_q <= mrz_pkg::MOD_DELAY_CK - 8'h01;
				end
				mrz_pkg::ST_WAIT: begin
					if (wait_cnt_q == 8'h00) begin
						state_q <= mrz_pkg::ST_IDLE;
					end else begin
						wait_cnt_q <= wait_cnt_q - 8'h01;
					end
				end
			endcase
		end
	end

	// Pins are flops; the command stands for exactly one clock
	wire issue_next = (state_q == mrz_pkg::ST_HOLD) & ready_to_issue;

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			LINK.cke <= 1'b0;
			LINK.cs_n <= 1'b1;
			LINK.ras_n <= 1'b1;
			LINK.cas_n <= 1'b1;
			LINK.we_n <= 1'b1;
			LINK.group_select_pins <= 2'h0;
			LINK.bank <= 2'h0;
			LINK.addr17 <= 1'b0;
			LINK.addr <= 14'h0000;
			LINK.termination_enable_pin <= 1'b0;
		end else begin
			LINK.cke <= 1'b1;
			LINK.cs_n <= ~issue_next;
			LINK.ras_n <= ~issue_next;
			LINK.cas_n <= ~issue_next;
			LINK.we_n <= ~issue_next;
			LINK.group_select_pins <= send_img[21:20];
			LINK.bank <= send_img[19:18];
			LINK.addr17 <= send_img[mrz_pkg::RFU_LO_BIT];
			LINK.addr <= send_img[13:0];
			LINK.termination_enable_pin <= ODT_REQ_I & ~hold_term_low;
		end
	end

endmodule : mrz_controller

// ===== mrz_properties.sv
`timescale 1ns/1ns
module mrz_properties (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic TERM_ENABLED_I,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] group_select_pins,
	input wire logic [1:0] bank,
	input wire logic addr17,
	input wire logic [13:0] addr,
	input wire logic termination_enable_pin
);
	logic [7:0] gap_q;
	logic [7:0] gap_d;
	wire in_window = (gap_q < mrz_pkg::MOD_DELAY_CK - 8'h01);
	wire mrs = !cs_n && !ras_n && !cas_n && !we_n;
	// Saturates so a quiet link never wraps into a fake window
	assign gap_d = mrs ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			gap_q <= 8'hFF;
		end else begin
			gap_q <= gap_d;
		end
	end
	// ****
	// Link rules
	// ****
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);
	a_cke_up_once: assert property (!cke |=> cke)
		else $error("clock enable not raised");
	a_mrs_cke_held: assert property (mrs |-> cke && $past(cke))
		else $error("mode write without clock enable");
	a_cmd_pins_low: assert property (!cs_n |-> !ras_n && !cas_n && !we_n)
		else $error("command strobes not all low");
	a_cmd_one_cycle: assert property (!cs_n |=> cs_n)
		else $error("command longer than one cycle");
	a_rfu_bits_zero: assert property (mrs |-> !group_select_pins[1] && !addr17)
		else $error("reserved bit set on link");
	a_sel_not_seven: assert property (mrs |-> {group_select_pins[0], bank} != 3'h7)
		else $error("forbidden select code issued");
	a_wr_code_legal: assert property (mrs |-> {addr[13], addr[11:9]} <= 4'h9)
		else $error("reserved recovery code issued");
	a_test_bit_zero: assert property (mrs |-> !addr[7])
		else $error("test setting bit issued");
	a_mod_spacing: assert property (!cs_n |-> gap_q >= mrz_pkg::MOD_DELAY_CK)
		else $error("command inside update window");
	a_term_held_low: assert property ((TERM_ENABLED_I && (mrs || in_window))
		|-> !termination_enable_pin && !$past(termination_enable_pin))
		else $error("termination pin high near mode write");
	c_sel_zero: cover property (mrs && {group_select_pins[0], bank} == 3'h0);
	c_sel_other: cover property (mrs && bank != 2'h0);
	c_dll_reset: cover property (mrs && addr[8]);
	c_wr_clamped: cover property (mrs && addr[13] && addr[9]);
endmodule : mrz_properties

// ===== mode_register_zero_program_tb.sv
`timescale 1ns/1ns
module mode_register_zero_program_tb;
	logic clk, rst_b, psel, penable, pwrite, banks_idle, term_en, gear_down, odt_req, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, b_order, dll_rst, test_mode, mode_busy;
	logic [4:0] add_lat, wr_cyc, vio;
	logic [3:0] rtp_cyc;
	logic [5:0] cl_cyc;
	logic [6:0] rd_lat;
	logic [1:0] b_size;
	int n_fail = 0;
	int checks = 0;
	int n, m;
	int wr_tab [10] = '{10, 12, 14, 16, 18, 20, 24, 22, 26, 28};
	int cl_tab [24] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17, 19, 21,
		25, 26, 27, 28, 29, 30, 31, 32};
	always #4 clk = ~clk;
	mrz_cmd_if i_mrz_cmd_if ();
	mrz_controller #(.STACKED_DIE(1'b0)) i_mrz_controller (.SYS_CLK_I(clk), .RST_B_I(rst_b),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.BANKS_IDLE_I(banks_idle), .TERM_ENABLED_I(term_en), .GEAR_DOWN_I(gear_down),
		.ODT_REQ_I(odt_req), .LINK(i_mrz_cmd_if));
	mrz_device i_mrz_device (.SYS_CLK_I(clk), .RST_B_I(rst_b), .LINK(i_mrz_cmd_if),
		.ADDITIVE_LAT_I(add_lat), .TERM_ENABLED_I(term_en), .WR_CYCLES_O(wr_cyc),
		.RTP_CYCLES_O(rtp_cyc), .CAS_LAT_O(cl_cyc), .READ_LAT_O(rd_lat),
		.BURST_ORDER_O(b_order), .BURST_SIZE_O(b_size), .DLL_RESET_O(dll_rst),
		.TEST_MODE_O(test_mode), .MODE_BUSY_O(mode_busy), .VIOLATION_O(vio));
	mrz_properties i_mrz_properties (.SYS_CLK_I(clk), .RST_B_I(rst_b),
		.TERM_ENABLED_I(term_en), .cke(i_mrz_cmd_if.cke), .cs_n(i_mrz_cmd_if.cs_n),
		.ras_n(i_mrz_cmd_if.ras_n), .cas_n(i_mrz_cmd_if.cas_n), .we_n(i_mrz_cmd_if.we_n),
		.group_select_pins(i_mrz_cmd_if.group_select_pins), .bank(i_mrz_cmd_if.bank),
		.addr17(i_mrz_cmd_if.addr17), .addr(i_mrz_cmd_if.addr),
		.termination_enable_pin(i_mrz_cmd_if.termination_enable_pin));
	// ****
	// Helpers
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		if (pready !== 1'h1) n_fail++;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic start(input logic [31:0] img);
		apb(1'h1, mrz_pkg::OFS_IMAGE, img);
		apb(1'h1, mrz_pkg::OFS_COMMAND, 32'h1);
	endtask : start
	// Leaves the last status word in rd
	task automatic settle;
		int k;
		k = 0;
		do begin
			apb(1'h0, mrz_pkg::OFS_STATUS, 32'h0);
			k++;
		end while (rd[0] !== 1'h0 && k < 60);
		if (rd[0] !== 1'h0) n_fail++;
	endtask : settle
	task automatic run(input logic [31:0] img);
		start(img);
		settle;
	endtask : run
	function automatic logic [31:0] img_of(input logic [3:0] w, input logic [4:0] c,
		input logic bt, input logic [1:0] bl);
		return {18'h0, w[3], c[4], w[2:0], 2'h0, c[3:1], bt, c[0], bl};
	endfunction : img_of
	task automatic check_dev(input int w, input int c, input logic bt, input logic [1:0] bl);
		check(32'(wr_cyc), 32'(w));
		check(32'(rtp_cyc), 32'(w / 2));
		check(32'(cl_cyc), 32'(c));
		check(32'(rd_lat), 32'(c) + 32'(add_lat));
		check(32'(b_order), 32'(bt));
		check(32'(b_size), 32'(bl));
	endtask : check_dev
	task automatic test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		test_done;
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{clk, rst_b, psel, penable, pwrite, gear_down} = 6'h00;
		{banks_idle, term_en, odt_req} = 3'h7;
		paddr = 8'h00;
		pwdata = 32'h0;
		add_lat = 5'h03;
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, mrz_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, mrz_pkg::OFS_IMAGE, 32'h0);
		check(rd, 32'(mrz_pkg::IMAGE_RST));
		apb(1'h0, 8'h0C, 32'h0);
		check({rd[30:0], er}, 32'h1);
		check_dev(10, 9, 1'h0, 2'h0);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			if (i == 16 || i == 18) continue;
			run(img_of(4'(i % 10), 5'(i), 1'(i), 2'(i % 3)));
			check(rd & 32'h2, 32'h0);
			check_dev(wr_tab[i % 10], cl_tab[i], 1'(i), 2'(i % 3));
		end
		check(32'(vio), 32'h0);
		$display("test table done");
		// Reserved bits, test bit, DLL reset and an oversized recovery code in one write
		start(img_of(4'hF, 5'h1, 1'h0, 2'h0) | 32'h0022_0180);
		n = 0;
		m = 0;
		repeat (60) begin
			@(posedge clk);
			if (dll_rst === 1'h1) n++;
			if (mode_busy === 1'h1) m++;
		end
		check(32'(n), 32'(mrz_pkg::DLL_RESET_CK));
		check(32'(m), 32'(mrz_pkg::MOD_DELAY_CK));
		settle;
		check_dev(28, 10, 1'h0, 2'h0);
		check(32'(test_mode), 32'h0);
		check(32'(vio), 32'h0);
		$display("test clamp done");
		run(img_of(4'h0, 5'h3, 1'h1, 2'h1) | 32'h0004_0000);
		check_dev(28, 10, 1'h0, 2'h0);
		run(img_of(4'h0, 5'h3, 1'h1, 2'h1) | 32'h001C_0000);
		check(rd & 32'h2, 32'h2);
		run(img_of(4'h0, 5'h10, 1'h0, 2'h0));
		check(rd & 32'h2, 32'h2);
		check_dev(28, 10, 1'h0, 2'h0);
		$display("test select done");
		gear_down <= 1'h1;
		run(img_of(4'h1, 5'h0, 1'h0, 2'h0));
		check(rd & 32'h2, 32'h2);
		run(img_of(4'h1, 5'h1, 1'h1, 2'h1));
		check(rd & 32'h2, 32'h0);
		check_dev(12, 10, 1'h1, 2'h1);
		gear_down <= 1'h0;
		$display("test gear done");
		banks_idle <= 1'h0;
		start(img_of(4'h2, 5'h3, 1'h0, 2'h0));
		repeat (40) @(posedge clk);
		apb(1'h0, mrz_pkg::OFS_STATUS, 32'h0);
		check(rd & 32'h1, 32'h1);
		check(32'(i_mrz_cmd_if.termination_enable_pin), 32'h0);
		check_dev(12, 10, 1'h1, 2'h1);
		banks_idle <= 1'h1;
		settle;
		check_dev(14, 12, 1'h0, 2'h0);
		$display("test idle done");
		term_en <= 1'h0;
		start(img_of(4'h3, 5'h3, 1'h0, 2'h0));
		repeat (4) @(posedge clk);
		check(32'(i_mrz_cmd_if.termination_enable_pin), 32'h1);
		settle;
		term_en <= 1'h1;
		check_dev(16, 12, 1'h0, 2'h0);
		check(32'(vio), 32'h0);
		$display("test termination done");
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, mrz_pkg::OFS_IMAGE, 32'h0);
		check(rd, 32'(mrz_pkg::IMAGE_RST));
		check_dev(10, 9, 1'h0, 2'h0);
		check(32'(dll_rst), 32'h0);
		$display("test reset again done");
		test_done;
	end
endmodule : mode_register_zero_program_tb
